// ==== shared/msd_pkg.sv ====
// shared constants, register map and state codes of the motor start/stop
// and direction controller; assumes a 10 MHz APB clock
package msd_pkg;

    // ------------------------------------------------------------------
    // register map (byte offsets)
    // ------------------------------------------------------------------
    localparam logic [7:0] MSD_OFS_CTRL = 8'h00;
    localparam logic [7:0] MSD_OFS_DEAD = 8'h04;
    localparam logic [7:0] MSD_OFS_STOPT = 8'h08;
    localparam logic [7:0] MSD_OFS_PROC = 8'h0C;
    localparam logic [7:0] MSD_OFS_THR = 8'h10;
    localparam logic [7:0] MSD_OFS_STAT = 8'h14;

    // ------------------------------------------------------------------
    // control register fields and reset values
    // ------------------------------------------------------------------
    localparam int MSD_CTRL_LEVEL = 0;
    localparam int MSD_CTRL_STOP_EN = 1;
    localparam int MSD_CTRL_REV_EN = 2;
    localparam int MSD_CTRL_BRAKE = 3;
    localparam int MSD_CTRL_CMP = 4;
    localparam int MSD_CTRL_W = 5;
    localparam logic [4:0] MSD_CTRL_RST = 5'h02;
    localparam logic [15:0] MSD_DEAD_RST = 16'h0064;
    localparam logic [15:0] MSD_STOPT_RST = 16'h000A;
    localparam logic [15:0] MSD_PROC_RST = 16'h0000;
    localparam logic [15:0] MSD_THR_LO_RST = 16'h0FA0;
    localparam logic [15:0] MSD_THR_HI_RST = 16'h1770;

    // ------------------------------------------------------------------
    // status register fields
    // ------------------------------------------------------------------
    localparam int MSD_ST_STATE = 0;
    localparam int MSD_ST_FWD_RELAY = 8;
    localparam int MSD_ST_REV_RELAY = 9;
    localparam int MSD_ST_DIR = 10;
    localparam int MSD_ST_CONFLICT = 11;
    localparam int MSD_ST_CMP_RUN = 12;
    localparam int MSD_ST_INPUTS = 13;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int unsigned MSD_CLK_PERIOD_NS = 100;
    localparam int unsigned MSD_MS_TIME_NS = 1000000;
    localparam int unsigned MSD_MS_TICK_CYCLES =
        (MSD_MS_TIME_NS + MSD_CLK_PERIOD_NS - 1) / MSD_CLK_PERIOD_NS;
    localparam int unsigned MSD_CHG_TIME_MS = 100;
    localparam logic [15:0] MSD_CHG_TICKS = 16'(MSD_CHG_TIME_MS);

    // ------------------------------------------------------------------
    // sequencer states
    // ------------------------------------------------------------------
    typedef enum logic [5:0] {
        MSD_IDLE = 6'h01,
        MSD_RUN = 6'h02,
        MSD_DEAD = 6'h04,
        MSD_BRAKE = 6'h08,
        MSD_STOP = 6'h10,
        MSD_GAP = 6'h20
    } msd_state_t;

endpackage : msd_pkg

// ==== shared/msd_cfg_if.sv ====
// configuration and status bundle between register file and sequencer
// assumes both ends run on the same pclk
`timescale 1ns/100ps
`default_nettype none
interface msd_cfg_if;
    logic level_mode;
    logic stop_en;
    logic rev_en;
    logic brake_en;
    logic cmp_en;
    logic [15:0] dead_ms;
    logic [15:0] stop_ms;
    logic [15:0] proc_val;
    logic [15:0] thr_lo;
    logic [15:0] thr_hi;
    logic [31:0] status;

    modport regs (
        output level_mode, stop_en, rev_en, brake_en, cmp_en,
        output dead_ms, stop_ms, proc_val, thr_lo, thr_hi,
        input status
    );
    modport core (
        input level_mode, stop_en, rev_en, brake_en, cmp_en,
        input dead_ms, stop_ms, proc_val, thr_lo, thr_hi,
        output status
    );
endinterface : msd_cfg_if
`default_nettype wire

// ==== core/msd_apb_regs.sv ====
// APB slave register file of the motor start/stop and direction controller
// assumes an APB master on pclk; zero wait states, slverr on unmapped access
`timescale 1ns/100ps
`default_nettype none
module msd_apb_regs
    import msd_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    msd_cfg_if.regs cfg
);

    // ------------------------------------------------------------------
    // decode
    // ------------------------------------------------------------------
    logic [4:0] ctrl_r, ctrl_nxt;
    logic [15:0] dead_r, dead_nxt, stopt_r, stopt_nxt, proc_r, proc_nxt;
    logic [15:0] lo_r, lo_nxt, hi_r, hi_nxt;
    logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic setup, wr_en;

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == MSD_OFS_CTRL) || (a == MSD_OFS_DEAD) ||
                 (a == MSD_OFS_STOPT) || (a == MSD_OFS_PROC) ||
                 (a == MSD_OFS_THR) || (a == MSD_OFS_STAT);
    endfunction : mapped

    assign setup = psel && !penable;
    assign wr_en = psel && penable && pready_r && pwrite && mapped(paddr);

    // ------------------------------------------------------------------
    // bus handshake and registers
    // ------------------------------------------------------------------
    always_comb begin
        pready_nxt = setup;
        pslverr_nxt = setup && !mapped(paddr);
        prdata_nxt = prdata_r;
        if (setup) begin
            unique case (paddr)
                MSD_OFS_CTRL: prdata_nxt = {27'h0000000, ctrl_r};
                MSD_OFS_DEAD: prdata_nxt = {16'h0000, dead_r};
                MSD_OFS_STOPT: prdata_nxt = {16'h0000, stopt_r};
                MSD_OFS_PROC: prdata_nxt = {16'h0000, proc_r};
                MSD_OFS_THR: prdata_nxt = {hi_r, lo_r};
                MSD_OFS_STAT: prdata_nxt = cfg.status;
                default: prdata_nxt = 32'h00000000;
            endcase
        end
        ctrl_nxt = ctrl_r;
        dead_nxt = dead_r;
        stopt_nxt = stopt_r;
        proc_nxt = proc_r;
        lo_nxt = lo_r;
        hi_nxt = hi_r;
        if (wr_en) begin
            unique case (paddr)
                MSD_OFS_CTRL: ctrl_nxt = pwdata[MSD_CTRL_W-1:0];
                MSD_OFS_DEAD: dead_nxt = pwdata[15:0];
                MSD_OFS_STOPT: stopt_nxt = pwdata[15:0];
                MSD_OFS_PROC: proc_nxt = pwdata[15:0];
                MSD_OFS_THR: begin
                    lo_nxt = pwdata[15:0];
                    hi_nxt = pwdata[31:16];
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h00000000;
            ctrl_r <= MSD_CTRL_RST;
            dead_r <= MSD_DEAD_RST;
            stopt_r <= MSD_STOPT_RST;
            proc_r <= MSD_PROC_RST;
            lo_r <= MSD_THR_LO_RST;
            hi_r <= MSD_THR_HI_RST;
        end else begin
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            prdata_r <= prdata_nxt;
            ctrl_r <= ctrl_nxt;
            dead_r <= dead_nxt;
            stopt_r <= stopt_nxt;
            proc_r <= proc_nxt;
            lo_r <= lo_nxt;
            hi_r <= hi_nxt;
        end
    end

    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign prdata = prdata_r;
    assign cfg.level_mode = ctrl_r[MSD_CTRL_LEVEL];
    assign cfg.stop_en = ctrl_r[MSD_CTRL_STOP_EN];
    assign cfg.rev_en = ctrl_r[MSD_CTRL_REV_EN];
    assign cfg.brake_en = ctrl_r[MSD_CTRL_BRAKE];
    assign cfg.cmp_en = ctrl_r[MSD_CTRL_CMP];
    assign cfg.dead_ms = dead_r;
    assign cfg.stop_ms = stopt_r;
    assign cfg.proc_val = proc_r;
    assign cfg.thr_lo = lo_r;
    assign cfg.thr_hi = hi_r;

endmodule : msd_apb_regs
`default_nettype wire

// ==== core/msd_ctrl.sv ====
// top of the motor start/stop and direction controller: input decode,
// run/stop/brake sequencer and contactor relay drive
// assumes inputs synchronous to pclk (10 MHz) and contact-closed = 1
//
// Local design decisions: the register offsets and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
module msd_ctrl
    import msd_pkg::*;
#(
    parameter int unsigned MS_TICK_CYCLES = MSD_MS_TICK_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    input wire logic run_forward_input,
    input wire logic stop_command_input,
    input wire logic run_reverse_input,
    output logic first_relay_output,
    output logic second_relay_output
);

    localparam int PW = $clog2(MS_TICK_CYCLES + 1);

    // ------------------------------------------------------------------
    // register file
    // ------------------------------------------------------------------
    msd_cfg_if cfg_bus ();

    msd_apb_regs u_regs (
        .pclk(pclk),
        .presetn(presetn),
        .paddr(paddr),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .pwdata(pwdata),
        .pready(pready),
        .prdata(prdata),
        .pslverr(pslverr),
        .cfg(cfg_bus.regs)
    );

    // ------------------------------------------------------------------
    // input decode
    // ------------------------------------------------------------------
    logic primed_r, primed_nxt, fwd_prev_r, fwd_prev_nxt;
    logic rev_prev_r, rev_prev_nxt, cmp_run_r, cmp_run_nxt;
    logic fwd_rise, rev_rise, powerup_start, stop_ok, conflict, demand;
    logic start_fwd, start_rev, stop_req, level, rev_on;

    assign level = cfg_bus.level_mode;
    assign rev_on = cfg_bus.rev_en && !level;
    assign stop_ok = !cfg_bus.stop_en || stop_command_input;
    assign fwd_rise = primed_r && run_forward_input && !fwd_prev_r;
    assign rev_rise = primed_r && run_reverse_input && !rev_prev_r;
    // maintained forward contact closed through power-up counts as a start only with the stop input enabled and closed
    assign powerup_start = !primed_r && run_forward_input &&
                           cfg_bus.stop_en && stop_command_input;
    assign conflict = rev_on && run_forward_input && run_reverse_input;
    assign demand = cfg_bus.cmp_en ? cmp_run_r : run_forward_input;

    always_comb begin
        primed_nxt = 1'b1;
        fwd_prev_nxt = run_forward_input;
        rev_prev_nxt = run_reverse_input;
        cmp_run_nxt = cmp_run_r;
        if (cfg_bus.proc_val < cfg_bus.thr_lo) begin
            cmp_run_nxt = 1'b1;
        end else if (cfg_bus.proc_val >= cfg_bus.thr_hi) begin
            cmp_run_nxt = 1'b0;
        end
        if (level) begin
            start_fwd = demand && stop_ok;
            start_rev = 1'b0;
            stop_req = !demand || !stop_ok;
        end else begin
            start_fwd = (fwd_rise || powerup_start) && stop_ok &&
                        !(rev_on && run_reverse_input);
            start_rev = rev_on && rev_rise && stop_ok &&
                        !run_forward_input;
            stop_req = !stop_ok || conflict;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            primed_r <= 1'b0;
            fwd_prev_r <= 1'b0;
            rev_prev_r <= 1'b0;
            cmp_run_r <= 1'b0;
        end else begin
            primed_r <= primed_nxt;
            fwd_prev_r <= fwd_prev_nxt;
            rev_prev_r <= rev_prev_nxt;
            cmp_run_r <= cmp_run_nxt;
        end
    end

    // ------------------------------------------------------------------
    // millisecond timer
    // ------------------------------------------------------------------
    logic [PW-1:0] presc_r, presc_nxt;
    logic [15:0] timer_r, timer_nxt, load_val;
    logic tick, load;

    function automatic logic [15:0] ms_load(input logic [15:0] ms);
        ms_load = (ms == 16'h0000) ? 16'h0001 : ms;
    endfunction : ms_load

    assign tick = (presc_r == PW'(MS_TICK_CYCLES - 1));

    always_comb begin
        presc_nxt = (load || tick) ? '0 : PW'(presc_r + 1'b1);
        timer_nxt = timer_r;
        if (load) begin
            timer_nxt = load_val;
        end else if (tick && timer_r != 16'h0000) begin
            timer_nxt = timer_r - 16'h0001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            presc_r <= '0;
            timer_r <= 16'h0000;
        end else begin
            presc_r <= presc_nxt;
            timer_r <= timer_nxt;
        end
    end

    // ------------------------------------------------------------------
    // sequencer and relay drive
    // ------------------------------------------------------------------
    msd_state_t state_r, state_nxt;
    logic dir_r, dir_nxt, fwd_rly_r, fwd_rly_nxt, rev_rly_r, rev_rly_nxt;
    logic [15:0] gap_ms;
    logic t_done;

    assign t_done = (timer_r == 16'h0000);
    assign gap_ms = rev_on ? MSD_CHG_TICKS : ms_load(cfg_bus.dead_ms);

    always_comb begin
        state_nxt = state_r;
        dir_nxt = dir_r;
        load = 1'b0;
        load_val = 16'h0000;
        unique case (state_r)
            MSD_IDLE: begin
                if (start_fwd && !conflict) begin
                    state_nxt = MSD_RUN;
                    dir_nxt = 1'b0;
                end else if (start_rev && !conflict) begin
                    state_nxt = MSD_RUN;
                    dir_nxt = 1'b1;
                end
            end
            MSD_RUN: begin
                if (stop_req && cfg_bus.brake_en) begin
                    state_nxt = MSD_DEAD;
                    load = 1'b1;
                    load_val = ms_load(cfg_bus.dead_ms);
                end else if (stop_req) begin
                    state_nxt = MSD_STOP;
                    load = 1'b1;
                    load_val = ms_load(cfg_bus.stop_ms);
                end
            end
            MSD_DEAD: begin
                if (t_done) begin
                    state_nxt = MSD_BRAKE;
                    load = 1'b1;
                    load_val = ms_load(cfg_bus.stop_ms);
                end
            end
            MSD_BRAKE, MSD_STOP: begin
                if (t_done) begin
                    state_nxt = MSD_GAP;
                    load = 1'b1;
                    load_val = gap_ms;
                end
            end
            MSD_GAP: begin
                if (t_done) begin
                    state_nxt = MSD_IDLE;
                end
            end
            default: state_nxt = MSD_IDLE;
        endcase
        fwd_rly_nxt = 1'b0;
        rev_rly_nxt = 1'b0;
        if (state_nxt == MSD_RUN || state_nxt == MSD_STOP) begin
            fwd_rly_nxt = !dir_nxt;
            rev_rly_nxt = dir_nxt;
        end else if (state_nxt == MSD_BRAKE) begin
            fwd_rly_nxt = dir_nxt;
            rev_rly_nxt = !dir_nxt;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= MSD_IDLE;
            dir_r <= 1'b0;
            fwd_rly_r <= 1'b0;
            rev_rly_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            dir_r <= dir_nxt;
            fwd_rly_r <= fwd_rly_nxt;
            rev_rly_r <= rev_rly_nxt;
        end
    end

    assign first_relay_output = fwd_rly_r;
    assign second_relay_output = rev_rly_r;
    assign cfg_bus.status = {16'h0000, run_reverse_input,
        stop_command_input, run_forward_input, cmp_run_r, conflict,
        dir_r, rev_rly_r, fwd_rly_r, 2'b00, state_r};

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_brake_entry;
        state_r == MSD_RUN && stop_req && cfg_bus.brake_en;
    endsequence

    sequence s_dead_end;
        state_r == MSD_DEAD && t_done;
    endsequence

    a_relays_exclusive: assert property (
        !(fwd_rly_r && rev_rly_r))
        else $error("both contactor relays energised");

    a_brake_release: assert property (
        s_brake_entry |=> state_r == MSD_DEAD && !fwd_rly_r &&
        !rev_rly_r && timer_r == ms_load($past(cfg_bus.dead_ms)))
        else $error("run relay not released at brake stop");

    a_brake_swap: assert property (
        s_dead_end |=> state_r == MSD_BRAKE && fwd_rly_r == dir_r &&
        rev_rly_r == !dir_r)
        else $error("brake relay not energised after dead time");

    a_stop_holds_relay: assert property (
        state_r == MSD_STOP && !t_done |=> fwd_rly_r == $past(fwd_rly_r)
        && rev_rly_r == $past(rev_rly_r))
        else $error("relay released before stop finished");

    a_gap_length: assert property (
        $rose(state_r == MSD_GAP) && rev_on |->
        timer_r == MSD_CHG_TICKS ##1 (state_r == MSD_GAP) [*8])
        else $error("change-over delay not applied");

    a_fwd_open_ignored: assert property (
        state_r == MSD_RUN && !level && !stop_req |=>
        state_r == MSD_RUN)
        else $error("run state left without stop");

    a_conflict_blocks: assert property (
        state_r == MSD_IDLE && conflict |=> state_r == MSD_IDLE)
        else $error("start taken during input conflict");

    a_level_stop: assert property (
        state_r == MSD_RUN && level && !demand && !cfg_bus.brake_en |=>
        state_r == MSD_STOP)
        else $error("level mode did not stop on open input");

    a_start_needs_stop: assert property (
        state_r == MSD_IDLE && !stop_ok |=> !fwd_rly_r && !rev_rly_r)
        else $error("start accepted with stop input open");

    a_no_powerup_edge: assert property (
        !primed_r && !(cfg_bus.stop_en && stop_command_input) &&
        !level |=> state_r == MSD_IDLE)
        else $error("start from level seen at power-up");

    a_cmp_hyst: assert property (
        cfg_bus.proc_val >= cfg_bus.thr_hi &&
        cfg_bus.proc_val >= cfg_bus.thr_lo |=> !cmp_run_r)
        else $error("comparator run not cleared at high threshold");

endmodule : msd_ctrl
`default_nettype wire

// ==== sim/msd_plant.sv ====
// model of the command switches and the two mains contactors
// assumes the bench sets contact commands; all on one pclk
`timescale 1ns/100ps
`default_nettype none
module msd_plant (
    input wire logic pclk,
    input wire logic fwd_cmd,
    input wire logic stop_cmd,
    input wire logic rev_cmd,
    input wire logic first_relay_output,
    input wire logic second_relay_output,
    output logic run_forward_input,
    output logic stop_command_input,
    output logic run_reverse_input,
    output logic both_on
);
    initial begin
        run_forward_input = 1'b0;
        stop_command_input = 1'b1;
        run_reverse_input = 1'b0;
        both_on = 1'b0;
    end
    // contacts change just after the edge; stop held closed to allow a start
    always @(posedge pclk) begin
        run_forward_input <= fwd_cmd;
        stop_command_input <= stop_cmd;
        run_reverse_input <= rev_cmd;
    end
    // sticky flag: both contactors pulled in at once
    always @(posedge pclk) begin
        if (first_relay_output && second_relay_output) begin
            both_on <= 1'b1;
        end
    end
endmodule : msd_plant
`default_nettype wire

// ==== sim/tb.sv ====
// self-checking bench of the start/stop and direction controller
// assumes a 10 MHz pclk and a 4-cycle millisecond in simulation
`timescale 1ns/100ps
`default_nettype none
module tb;
    import msd_pkg::*;
    localparam int unsigned M = 4;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic fwd = 1'b0;
    logic stp = 1'b1;
    logic rev = 1'b0;
    logic pready, pslverr, fin, sin, rin, rl1, rl2, both_on;
    logic [31:0] prdata;
    int n_errors = 0;
    int num_checks = 0;

    always #50 pclk = ~pclk;

    msd_ctrl #(.MS_TICK_CYCLES(M)) dut (.pclk(pclk), .presetn(presetn),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .run_forward_input(fin),
        .stop_command_input(sin), .run_reverse_input(rin),
        .first_relay_output(rl1), .second_relay_output(rl2));
    msd_plant plant (.pclk(pclk), .fwd_cmd(fwd), .stop_cmd(stp),
        .rev_cmd(rev), .first_relay_output(rl1),
        .second_relay_output(rl2), .run_forward_input(fin),
        .stop_command_input(sin), .run_reverse_input(rin),
        .both_on(both_on));

    // ------------------------------------------------------------------
    // bus, pin and compare tasks
    // ------------------------------------------------------------------
    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk_reg

    task automatic chk_rly(input logic [1:0] exp);
        num_checks++;
        if ({rl1, rl2} !== exp) begin
            n_errors++;
            $display("ERROR %0t got %h exp %h", $time, {rl1, rl2}, exp);
        end
    endtask : chk_rly

    task automatic apb(input logic wr, input logic [7:0] a,
        input logic [31:0] wd, output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        // a hung slave is caught by the watchdog, which ends the run
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic e;
        apb(1'b1, a, d, rd, e);
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp,
        input logic experr);
        logic [31:0] rd;
        logic e;
        apb(1'b0, a, 32'h0, rd, e);
        chk_reg(rd, exp);
        chk_reg({31'h0, e}, {31'h0, experr});
    endtask : rd_chk

    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask : cyc

    task automatic setin(input logic f, input logic s, input logic r);
        @(posedge pclk);
        fwd <= f;
        stp <= s;
        rev <= r;
    endtask : setin

    task automatic wait_rl(input logic [1:0] exp, input int mx);
        int n;
        n = 0;
        while ({rl1, rl2} !== exp && n < mx) begin
            @(posedge pclk);
            n++;
        end
        chk_rly(exp);
    endtask : wait_rl

    task automatic rst(input logic f, input logic s);
        setin(f, s, 1'b0);
        presetn <= 1'b0;
        cyc(12);
        presetn <= 1'b1;
    endtask : rst

    task automatic end_of_test;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : end_of_test

    // ------------------------------------------------------------------
    // tests
    // ------------------------------------------------------------------
    initial begin
        rst(1'b0, 1'b1);
        rd_chk(MSD_OFS_CTRL, 32'h0000_0002, 1'b0);
        rd_chk(MSD_OFS_DEAD, 32'h0000_0064, 1'b0);
        rd_chk(MSD_OFS_STOPT, 32'h0000_000A, 1'b0);
        rd_chk(MSD_OFS_THR, 32'h1770_0FA0, 1'b0);
        rd_chk(8'h18, 32'h0, 1'b1);
        chk_rly(2'b00);
        $display("test regs done");
        setin(1'b1, 1'b1, 1'b0);
        wait_rl(2'b10, 5);
        setin(1'b0, 1'b1, 1'b0);
        cyc(10);
        chk_rly(2'b10);
        setin(1'b1, 1'b0, 1'b0);
        cyc(20);
        chk_rly(2'b10);
        wait_rl(2'b00, 60);
        cyc(450);
        setin(1'b1, 1'b1, 1'b0);
        cyc(20);
        chk_rly(2'b00);
        setin(1'b0, 1'b0, 1'b0);
        setin(1'b1, 1'b0, 1'b0);
        cyc(10);
        chk_rly(2'b00);
        setin(1'b0, 1'b1, 1'b0);
        $display("test edge done");
        wr(MSD_OFS_CTRL, 32'h6);
        setin(1'b0, 1'b1, 1'b1);
        wait_rl(2'b01, 5);
        setin(1'b0, 1'b1, 1'b0);
        cyc(10);
        chk_rly(2'b01);
        rd_chk(MSD_OFS_STAT, 32'h0000_5602, 1'b0);
        setin(1'b0, 1'b0, 1'b0);
        wait_rl(2'b00, 60);
        setin(1'b0, 1'b1, 1'b0);
        cyc(360);
        setin(1'b1, 1'b1, 1'b0);
        setin(1'b0, 1'b1, 1'b0);
        cyc(5);
        chk_rly(2'b00);
        cyc(40);
        setin(1'b1, 1'b1, 1'b0);
        wait_rl(2'b10, 5);
        setin(1'b1, 1'b1, 1'b1);
        wait_rl(2'b00, 60);
        cyc(450);
        setin(1'b0, 1'b1, 1'b1);
        setin(1'b1, 1'b1, 1'b1);
        cyc(10);
        chk_rly(2'b00);
        setin(1'b0, 1'b1, 1'b0);
        $display("test direction done");
        wr(MSD_OFS_CTRL, 32'hE);
        wr(MSD_OFS_DEAD, 32'h2);
        setin(1'b1, 1'b1, 1'b0);
        wait_rl(2'b10, 5);
        setin(1'b0, 1'b0, 1'b0);
        wait_rl(2'b00, 3);
        wait_rl(2'b01, 15);
        wait_rl(2'b00, 60);
        setin(1'b0, 1'b1, 1'b0);
        cyc(450);
        setin(1'b0, 1'b1, 1'b1);
        wait_rl(2'b01, 5);
        setin(1'b0, 1'b0, 1'b0);
        wait_rl(2'b00, 3);
        wait_rl(2'b10, 15);
        wait_rl(2'b00, 60);
        setin(1'b0, 1'b1, 1'b0);
        cyc(450);
        $display("test brake done");
        wr(MSD_OFS_CTRL, 32'h1);
        setin(1'b1, 1'b1, 1'b0);
        wait_rl(2'b10, 5);
        setin(1'b0, 1'b1, 1'b0);
        wait_rl(2'b00, 60);
        cyc(450);
        // process value 0 since reset latched a run demand; clear it first
        wr(MSD_OFS_PROC, 32'h1770);
        wr(MSD_OFS_PROC, 32'h1388);
        wr(MSD_OFS_CTRL, 32'h11);
        cyc(10);
        chk_rly(2'b00);
        wr(MSD_OFS_PROC, 32'h0BB8);
        wait_rl(2'b10, 10);
        wr(MSD_OFS_PROC, 32'h1388);
        cyc(10);
        chk_rly(2'b10);
        wr(MSD_OFS_PROC, 32'h1770);
        wait_rl(2'b00, 60);
        $display("test level done");
        rst(1'b1, 1'b1);
        wait_rl(2'b10, 5);
        setin(1'b1, 1'b0, 1'b0);
        wait_rl(2'b00, 60);
        rst(1'b1, 1'b0);
        cyc(5);
        setin(1'b1, 1'b1, 1'b0);
        cyc(10);
        chk_rly(2'b00);
        chk_reg({31'h0, both_on}, 32'h0);
        $display("test power done");
        end_of_test();
    end

    initial begin
        repeat (20000) @(posedge pclk);
        n_errors++;
        end_of_test();
    end
endmodule : tb
`default_nettype wire
